// *** hdl/ddt_pkg.sv ***
package ddt_pkg;

    // Instruction-level write ports of the core.
    typedef struct packed {
        logic       wr_a_mode;
        logic       wr_b_mode;
        logic       wr_a_low;
        logic       wr_a_high;
        logic       wr_b_low;
        logic       wr_b_high;
        logic [3:0] data;
    } ddt_wr_t;

    // Flag-register commands from the core.
    typedef struct packed {
        logic       wr_ief;
        logic       wr_hef;
        logic       wr_pef;
        logic       clr_evf;
        logic       en_int;
        logic       irq_global_disable_instr;
        logic [7:0] data;
    } ddt_flag_cmd_t;

    localparam int unsigned SYS_CLK_HZ    = 20000000;
    localparam int unsigned SUB_OSC_MHZ_X = 32768;
    localparam int unsigned PRESC_B_DIV   = 64;
    localparam int unsigned PRESC_A_SLOW  = 1024;
    localparam int unsigned PRESC_A_FAST  = 4;
    localparam int unsigned PRESC_W       = 10;

    localparam int unsigned MODE_CLK_SEL  = 0;
    localparam int unsigned MODE_SRC_SUB  = 1;
    localparam int unsigned MODE_PIN_SEL  = 2;
    localparam int unsigned MODE_START    = 3;
    localparam logic [3:0]  MODE_RESET    = 4'h0;

    localparam int unsigned EVF_TIMER_A   = 1;
    localparam int unsigned EVF_TIMER_B   = 7;
    localparam int unsigned N_SRC         = 8;
    localparam logic [7:0]  FLAGS_RESET   = 8'h00;
    localparam logic [7:0]  COUNT_RESET   = 8'h00;
    localparam logic [7:0]  UNDERFLOW_AT  = 8'h00;

    localparam logic [9:0]  VECTOR_BASE   = 10'h004;
    localparam logic [9:0]  VECTOR_STEP   = 10'h004;
    localparam logic [9:0]  VECTOR_LAST   = 10'h023;

endpackage

// *** hdl/ddt_timer_irq.sv ***
// Operation
// - Counter B is an 8-bit down-counter stepping once per selected input clock.
// - Mode bits 0 and 1 choose system clock, divide-by-64, or sub-oscillator.
// - After reset counter B is stopped, with the undivided system clock selected.
// - Writing either preset half stores to reload buffer and clears start bit.
// - Setting start copies buffer into counter, starts counting, clears flag 7.
// - Underflow 00 to FF sets flag 7, reloads and keeps counting.
// - Underflow requests interrupt if enable 7, releases hold if hold enable 7.
// - Mode bit 2 selects pin source: external generator or counter B tone.
// - Tone frequency is input clock over preset plus one, halved.
// - Underflow period is preset plus one input clock periods.
// - Mode bit 3 is counter B run control.
// - Counter B mode register is four write-only bits.
// - Counter A mode bit 0 selects system clock over 4 or over 1024.
// - Counter A mode bits 1 and 2 are reserved and unused.
// - Counter A mode bit 3 halts when low, counts down when high.
// - Interrupt requested when event flag meets enable, and port enable for ports.
// - Vector addresses lie between 004H and 023H.
// - Taking a vector clears that event flag and blocks further interrupts.
// - Interrupt in hold releases it temporarily, then hold resumes after service.
// - Writing counter A preset stops it, clears start, loads counter directly.
// - Counter A underflow 00 to FF stops it without reload and sets flag 1.
// - Event flags set by hardware, cleared by software or by their interrupt.
module ddt_timer_irq (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    // Core register writes and flag commands
    input  wire ddt_pkg::ddt_wr_t       i_wr,
    input  wire ddt_pkg::ddt_flag_cmd_t i_cmd,
    // Core interrupt handshake and hold state
    input  wire logic                   i_irq_ack,
    input  wire logic                   i_in_hold,
    input  wire logic                   i_ret_from_isr,
    // Other event sources and pin inputs
    input  wire logic [7:0]             i_ext_events,
    input  wire logic [7:0]             i_port_src_mask,
    input  wire logic                   i_sub_osc_clock,
    input  wire logic                   i_pin_gen_wave,
    // Outputs
    output logic                        o_irq_req,
    output logic [9:0]                  o_irq_vector,
    output logic                        o_hold_release,
    output logic                        o_hold_resume,
    output logic [7:0]                  o_event_flags,
    output logic [7:0]                  o_hold_cause,
    output logic                        o_multi_function_out_pin
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ISR  = 3'b010,
        ST_HISR = 3'b100
    } ddt_irq_st_t;

    localparam int unsigned PRESC_W_L = ddt_pkg::PRESC_W;

    logic [3:0]           a_mode_q;
    logic [3:0]           a_mode_d;
    logic [3:0]           b_mode_q;
    logic [3:0]           b_mode_d;
    logic [7:0]           a_cnt_q;
    logic [7:0]           a_cnt_d;
    logic [7:0]           b_cnt_q;
    logic [7:0]           b_cnt_d;
    logic [7:0]           b_buf_q;
    logic [7:0]           b_buf_d;
    logic [PRESC_W_L-1:0] presc_q;
    logic [PRESC_W_L-1:0] presc_d;
    logic                 sub_s1_q;
    logic                 sub_s2_q;
    logic                 sub_s3_q;
    logic                 tone_q;
    logic                 tone_d;
    logic [7:0]           evf_q;
    logic [7:0]           evf_d;
    logic [7:0]           ief_q;
    logic [7:0]           ief_d;
    logic [7:0]           hef_q;
    logic [7:0]           hef_d;
    logic [7:0]           pef_q;
    logic [7:0]           pef_d;
    logic [7:0]           hcf_q;
    logic [7:0]           hcf_d;
    logic                 gie_q;
    logic                 gie_d;
    ddt_irq_st_t          st_q;
    ddt_irq_st_t          st_d;
    logic [9:0]           vec_q;
    logic [9:0]           vec_d;
    logic                 req_q;
    logic                 req_d;
    logic                 tick_b;
    logic                 tick_a;
    logic                 uf_a;
    logic                 uf_b;
    logic                 b_start_rise;
    logic [7:0]           hw_set;
    logic [7:0]           pend;
    logic [2:0]           win;
    logic                 any_pend;

    // Prescaler and sub-oscillator edge as count enables.
    // One free-running prescaler feeds both counters, so no divided clock is ever built.
    always_comb begin
        presc_d = presc_q + 1'b1;
        tick_b  = 1'b1;
        tick_a  = 1'b0;
        if (b_mode_q[ddt_pkg::MODE_SRC_SUB]) begin
            tick_b = sub_s2_q & ~sub_s3_q;
        end else if (b_mode_q[ddt_pkg::MODE_CLK_SEL]) begin
            tick_b = presc_q[5:0] == 6'h3f;
        end
        if (a_mode_q[ddt_pkg::MODE_CLK_SEL]) begin
            tick_a = presc_q == 10'h3ff;
        end else begin
            tick_a = presc_q[1:0] == 2'h3;
        end
    end

    // Mode registers, counters, reload buffer and tone.
    always_comb begin
        a_mode_d     = a_mode_q;
        b_mode_d     = b_mode_q;
        a_cnt_d      = a_cnt_q;
        b_cnt_d      = b_cnt_q;
        b_buf_d      = b_buf_q;
        tone_d       = tone_q;
        uf_a         = 1'b0;
        uf_b         = 1'b0;
        b_start_rise = 1'b0;
        if (a_mode_q[ddt_pkg::MODE_START] && tick_a) begin
            a_cnt_d = a_cnt_q - 8'h01;
            if (a_cnt_q == ddt_pkg::UNDERFLOW_AT) begin
                uf_a                      = 1'b1;
                a_mode_d[ddt_pkg::MODE_START] = 1'b0;
            end
        end
        if (b_mode_q[ddt_pkg::MODE_START] && tick_b) begin
            b_cnt_d = b_cnt_q - 8'h01;
            if (b_cnt_q == ddt_pkg::UNDERFLOW_AT) begin
                uf_b    = 1'b1;
                b_cnt_d = b_buf_q;
                tone_d  = ~tone_q;
            end
        end
        if (i_wr.wr_a_mode) begin
            a_mode_d = {i_wr.data[3], 2'b00, i_wr.data[0]};
        end
        if (i_wr.wr_b_mode) begin
            b_mode_d = i_wr.data;
            if (i_wr.data[ddt_pkg::MODE_START] && !b_mode_q[ddt_pkg::MODE_START]) begin
                b_start_rise = 1'b1;
                b_cnt_d      = b_buf_q;
            end
        end
        if (i_wr.wr_a_low || i_wr.wr_a_high) begin
            a_mode_d[ddt_pkg::MODE_START] = 1'b0;
            if (i_wr.wr_a_low) begin
                a_cnt_d = {a_cnt_q[7:4], i_wr.data};
            end else begin
                a_cnt_d = {i_wr.data, a_cnt_q[3:0]};
            end
        end
        if (i_wr.wr_b_low || i_wr.wr_b_high) begin
            b_mode_d[ddt_pkg::MODE_START] = 1'b0;
            if (i_wr.wr_b_low) begin
                b_buf_d = {b_buf_q[7:4], i_wr.data};
            end else begin
                b_buf_d = {i_wr.data, b_buf_q[3:0]};
            end
        end
    end

    // Event flags, enables and hold causes; hardware set beats clear.
    always_comb begin
        hw_set = i_ext_events;
        hw_set[ddt_pkg::EVF_TIMER_A] = uf_a;
        hw_set[ddt_pkg::EVF_TIMER_B] = uf_b;
        evf_d = evf_q;
        if (i_cmd.clr_evf) begin
            evf_d = evf_q & ~i_cmd.data;
        end
        if (st_q == ST_IDLE && req_q && i_irq_ack) begin
            evf_d[win] = 1'b0;
        end
        if (b_start_rise) begin
            evf_d[ddt_pkg::EVF_TIMER_B] = 1'b0;
        end
        evf_d = evf_d | hw_set;
        ief_d = i_cmd.wr_ief ? i_cmd.data : ief_q;
        hef_d = i_cmd.wr_hef ? i_cmd.data : hef_q;
        pef_d = i_cmd.wr_pef ? i_cmd.data : pef_q;
        hcf_d = (hcf_q & evf_d & hef_d) | (hw_set & hef_q);
    end

    // Pending sources and fixed priority, lowest index first.
    // The vector is registered with the request, so both reach the core together.
    always_comb begin
        pend = evf_q & ief_q & (~i_port_src_mask | pef_q);
        win  = 3'd0;
        for (int i = ddt_pkg::N_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win = 3'(i);
            end
        end
        any_pend = |pend;
    end

    // Interrupt sequencing and hold interplay.
    always_comb begin
        st_d  = st_q;
        gie_d = gie_q;
        vec_d = vec_q;
        req_d = 1'b0;
        if (i_cmd.en_int || i_cmd.wr_ief) begin
            gie_d = 1'b1;
        end
        if (i_cmd.irq_global_disable_instr) begin
            gie_d = 1'b0;
        end
        unique case (st_q)
            ST_IDLE: begin
                req_d = gie_q & any_pend;
                vec_d = ddt_pkg::VECTOR_BASE + 10'(win) * ddt_pkg::VECTOR_STEP;
                if (req_q && i_irq_ack) begin
                    req_d = 1'b0;
                    gie_d = 1'b0;
                    st_d  = i_in_hold ? ST_HISR : ST_ISR;
                end
            end
            ST_ISR: begin
                if (i_ret_from_isr) begin
                    st_d = ST_IDLE;
                end
            end
            ST_HISR: begin
                if (i_ret_from_isr) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    // Registers only; every next value except the sub-oscillator synchroniser stages is formed in the processes above.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            a_mode_q <= ddt_pkg::MODE_RESET;
            b_mode_q <= ddt_pkg::MODE_RESET;
            a_cnt_q  <= ddt_pkg::COUNT_RESET;
            b_cnt_q  <= ddt_pkg::COUNT_RESET;
            b_buf_q  <= ddt_pkg::COUNT_RESET;
            presc_q  <= '0;
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
            tone_q   <= 1'b0;
            evf_q    <= ddt_pkg::FLAGS_RESET;
            ief_q    <= ddt_pkg::FLAGS_RESET;
            hef_q    <= ddt_pkg::FLAGS_RESET;
            pef_q    <= ddt_pkg::FLAGS_RESET;
            hcf_q    <= ddt_pkg::FLAGS_RESET;
            gie_q    <= 1'b0;
            st_q     <= ST_IDLE;
            vec_q    <= ddt_pkg::VECTOR_BASE;
            req_q    <= 1'b0;
        end else begin
            a_mode_q <= a_mode_d;
            b_mode_q <= b_mode_d;
            a_cnt_q  <= a_cnt_d;
            b_cnt_q  <= b_cnt_d;
            b_buf_q  <= b_buf_d;
            presc_q  <= presc_d;
            sub_s1_q <= i_sub_osc_clock;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
            tone_q   <= tone_d;
            evf_q    <= evf_d;
            ief_q    <= ief_d;
            hef_q    <= hef_d;
            pef_q    <= pef_d;
            hcf_q    <= hcf_d;
            gie_q    <= gie_d;
            st_q     <= st_d;
            vec_q    <= vec_d;
            req_q    <= req_d;
        end
    end

    assign o_irq_req                = req_q;
    assign o_irq_vector             = vec_q;
    assign o_event_flags            = evf_q;
    assign o_hold_cause             = hcf_q;
    assign o_hold_release           = (|hcf_q) | (st_q == ST_HISR);
    assign o_hold_resume            = (st_q == ST_HISR) && i_ret_from_isr;
    assign o_multi_function_out_pin = b_mode_q[ddt_pkg::MODE_PIN_SEL] ? tone_q : i_pin_gen_wave;

endmodule

// *** tb/ddt_core_model.sv ***
module ddt_core_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_irq_req,
    input  wire logic [7:0] i_wait,
    output logic            o_ack,
    output logic            o_en_int,
    output logic            o_ret
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_ack = 1'b0;
        o_en_int = 1'b0;
        o_ret = 1'b0;
        forever begin
            // The request is looked at once the edge that launches it has settled.
            @(posedge i_clk) #5;
            if (!i_rst && i_irq_req === 1'b1) begin
                repeat (i_wait) @(posedge i_clk) #5;
                o_ack = 1'b1;
                @(posedge i_clk) #5 o_ack = 1'b0;
                repeat (2) @(posedge i_clk);
                #5 o_en_int = 1'b1;
                @(posedge i_clk) #5 o_en_int = 1'b0;
                o_ret = 1'b1;
                @(posedge i_clk) #5 o_ret = 1'b0;
            end
        end
    end
endmodule

// *** tb/ddt_timer_irq_props.sv ***
module ddt_timer_irq_props (
    input wire logic                   i_clk,
    input wire logic                   i_rst,
    input wire ddt_pkg::ddt_wr_t       i_wr,
    input wire ddt_pkg::ddt_flag_cmd_t i_cmd,
    input wire logic                   i_irq_ack,
    input wire logic [7:0]             i_ext_events,
    input wire logic                   i_pin_gen_wave,
    input wire logic                   o_irq_req,
    input wire logic [9:0]             o_irq_vector,
    input wire logic                   o_hold_release,
    input wire logic [7:0]             o_event_flags,
    input wire logic [7:0]             o_hold_cause,
    input wire logic                   o_multi_function_out_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       sel_q;
    logic       sel_d;
    logic [3:0] idx;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Mirror of the pin source bit, since the mode register cannot be read.
    always_comb begin
        sel_d = i_wr.wr_b_mode ? i_wr.data[2] : sel_q;
    end
    always_ff @(posedge i_clk) begin
        sel_q <= i_rst ? 1'b0 : sel_d;
    end
    assign idx = 4'((o_irq_vector - 10'h004) >> 2);
    sequence acked_s; o_irq_req && i_irq_ack && !i_cmd.en_int && !i_cmd.wr_ief; endsequence
    sequence quiet_s; !i_cmd.en_int && !i_cmd.wr_ief; endsequence
    vec_range_a: assert property (o_irq_req |-> o_irq_vector >= 10'h004 && o_irq_vector <= 10'h023)
        else $error("vector out of range");
    ack_drop_a: assert property (acked_s |=> !o_irq_req)
        else $error("request held after ack");
    no_reirq_a: assert property (acked_s ##1 quiet_s |=> !o_irq_req)
        else $error("request before re-enable");
    ack_clear_a: assert property (acked_s and (idx != 4'h1 && idx != 4'h7 && i_ext_events == 8'h00)
        |=> !o_event_flags[$past(idx)]) else $error("flag kept after ack");
    sw_clear_a: assert property (i_cmd.clr_evf && i_ext_events == 8'h00
        |=> (o_event_flags & $past(i_cmd.data) & 8'h7d) == 8'h00) else $error("flag kept after clear");
    hold_rel_a: assert property (o_hold_cause != 8'h00 |-> o_hold_release)
        else $error("hold not released");
    irq_cause_a: assert property ($rose(o_irq_req) |-> $past(o_event_flags) != 8'h00)
        else $error("request without event");
    pin_gen_a: assert property (!sel_q |-> o_multi_function_out_pin == i_pin_gen_wave)
        else $error("pin not on generator");
    tone_flip_a: assert property ($rose(o_event_flags[7]) && sel_q && $past(sel_q)
        |-> $changed(o_multi_function_out_pin)) else $error("tone not toggled");
endmodule
bind ddt_timer_irq ddt_timer_irq_props chk_u (.i_clk, .i_rst, .i_wr, .i_cmd, .i_irq_ack, .i_ext_events,
    .i_pin_gen_wave, .o_irq_req, .o_irq_vector, .o_hold_release, .o_event_flags, .o_hold_cause,
    .o_multi_function_out_pin);

// *** tb/test_dual_down_timer_irq_unit.sv ***
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t got %h want %h", $time, a, e); end end
module test_dual_down_timer_irq_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   i_clk = 1'b0, i_rst = 1'b1, hold = 1'b0, sub = 1'b0, gen = 1'b0;
    ddt_pkg::ddt_wr_t       wr = '0;
    ddt_pkg::ddt_flag_cmd_t cmd = '0, cmd_mix;
    logic                   ack, ret, en, req, rel, res, pin;
    logic [7:0]             ext = '0, lat = '0, msk = '0, event_flags, hcf;
    logic [9:0]             vec;
    int                     n_mismatch = 0, n_compared = 0, n;
    ddt_core_model core_u (.i_clk(i_clk), .i_rst(i_rst), .i_irq_req(req), .i_wait(lat), .o_ack(ack),
        .o_en_int(en), .o_ret(ret));
    always_comb begin
        cmd_mix = cmd;
        cmd_mix.en_int = cmd.en_int | en;
    end
    ddt_timer_irq dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_wr(wr), .i_cmd(cmd_mix), .i_irq_ack(ack),
        .i_in_hold(hold), .i_ret_from_isr(ret), .i_ext_events(ext), .i_port_src_mask(msk),
        .i_sub_osc_clock(sub), .i_pin_gen_wave(gen), .o_irq_req(req), .o_irq_vector(vec),
        .o_hold_release(rel), .o_hold_resume(res), .o_event_flags(event_flags), .o_hold_cause(hcf),
        .o_multi_function_out_pin(pin));
    initial forever #25 i_clk = ~i_clk;
    initial forever #15250 sub = ~sub;
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr_b(input logic [5:0] s, input logic [3:0] d);
        @(posedge i_clk) #5 wr = {s, d};
        @(posedge i_clk) #5 wr = '0;
    endtask
    task automatic cm(input logic [5:0] s, input logic [7:0] d);
        @(posedge i_clk) #5 cmd = {s, d};
        @(posedge i_clk) #5 cmd = '0;
    endtask
    // Waits while the chosen signal (flag bit, 8 pin, 9 request, 10 resume) still equals v.
    // It looks one step after the stimulus delay, so pulses from the core model have settled.
    task automatic wait_on(input int b, input logic v, input int lim);
        n = 0;
        while (((b == 8) ? pin : (b == 9) ? req : (b == 10) ? res : event_flags[b]) === v) begin
            @(posedge i_clk) #6 n++;
            if (n > lim) begin
                n_mismatch++;
                $display("ERROR %0t wait timed out", $time);
                complete_run();
            end
        end
    endtask
    task automatic t_tone(input logic [1:0] src, input logic [7:0] p, input int lo, input int hi);
        logic v;
        wr_b(6'h02, p[3:0]);
        wr_b(6'h01, p[7:4]);
        wr_b(6'h10, {2'b11, src});
        `CHK(event_flags[7], 1'b0)
        v = pin;
        wait_on(8, v, 2000);
        v = pin;
        wait_on(8, v, 2000);
        `CHK(n >= lo && n <= hi, 1'b1)
    endtask
    task automatic t_stop;
        logic v;
        wr_b(6'h10, 4'hc);
        wr_b(6'h02, 4'h5);
        v = pin;
        repeat (50) @(posedge i_clk);
        #5 `CHK(pin, v)
        gen = ~v;
        wr_b(6'h10, 4'h0);
        `CHK(pin, gen)
    endtask
    task automatic t_irq;
        cm(6'h04, 8'hff);
        `CHK(event_flags, 8'h00)
        cm(6'h20, 8'h88);
        cm(6'h10, 8'h80);
        cm(6'h02, 8'h00);
        msk = 8'h08;
        @(posedge i_clk) #5 ext = 8'h08;
        @(posedge i_clk) #5 ext = 8'h00;
        repeat (4) @(posedge i_clk);
        #5 `CHK(req, 1'b0)
        cm(6'h08, 8'h08);
        wait_on(9, 1'b0, 20);
        `CHK(vec, 10'h010)
        wait_on(9, 1'b1, 50);
        `CHK(event_flags[3], 1'b0)
        repeat (8) @(posedge i_clk);
        #5 lat = 8'h06;
        hold = 1'b1;
        wr_b(6'h02, 4'hf);
        wr_b(6'h01, 4'h0);
        wr_b(6'h10, 4'h8);
        wait_on(9, 1'b0, 100);
        `CHK(vec, 10'h020)
        `CHK(rel, 1'b1)
        wait_on(9, 1'b1, 50);
        `CHK(event_flags[7], 1'b0)
        wr_b(6'h10, 4'h0);
        wait_on(10, 1'b0, 20);
        `CHK(res, 1'b1)
        hold = 1'b0;
    endtask
    task automatic t_a(input logic [3:0] m, input int lo, input int hi);
        wr_b(6'h08, 4'h3);
        wr_b(6'h04, 4'h0);
        wr_b(6'h20, m);
        wait_on(1, 1'b0, 5000);
        `CHK(n >= lo && n <= hi, 1'b1)
        cm(6'h04, 8'h02);
        repeat (1100) @(posedge i_clk);
        #5 `CHK(event_flags[1], 1'b0)
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        #5 i_rst = 1'b0;
        `CHK(event_flags, 8'h00)
        `CHK(req, 1'b0)
        gen = 1'b1;
        #1 `CHK(pin, 1'b1)
        t_tone(2'b00, 8'h12, 19, 19);
        t_tone(2'b01, 8'h01, 128, 128);
        t_tone(2'b10, 8'h00, 605, 615);
        t_stop();
        t_irq();
        t_a(4'he, 10, 20);
        t_a(4'h9, 3072, 4100);
        complete_run();
    end
endmodule
